// ---- rtl/adc_regs_pkg.sv ----
// register map package for the adc configuration register bank
// assumes a byte-wide register port driven by the serial command decoder
package adc_regs_pkg;

  // ==========================================
  // addresses
  localparam logic [2:0] addr_identity = 3'h0;
  localparam logic [2:0] addr_configuration = 3'h1;
  localparam logic [2:0] addr_offset_low = 3'h2;
  localparam logic [2:0] addr_offset_mid = 3'h3;
  localparam logic [2:0] addr_offset_high = 3'h4;
  localparam logic [2:0] addr_gain_low = 3'h5;
  localparam logic [2:0] addr_gain_high = 3'h6;
  localparam logic [2:0] addr_pin_settings = 3'h7;

  // ==========================================
  // field positions of the configuration register
  localparam int gain_correction_enable_bit = 5;
  localparam int offset_correction_enable_bit = 4;
  localparam int idle_timeout_length_select_bit = 3;
  localparam int serial_idle_timeout_enable_bit = 2;
  localparam int status_byte_disable_bit = 1;
  localparam int status_crc_width_select_bit = 0;
  localparam logic [7:0] configuration_writable_mask = 8'h3f;

  // ==========================================
  // reset values
  localparam logic [7:0] configuration_reset = 8'h00;
  localparam logic [7:0] offset_byte_reset = 8'h00;
  localparam logic [7:0] gain_low_reset = 8'h00;
  localparam logic [7:0] gain_high_reset = 8'h80;

  // ==========================================
  // timeout lengths in master clock periods
  localparam logic [16:0] idle_timeout_long_cycles = 17'h1_0000;
  localparam logic [16:0] idle_timeout_short_cycles = 17'h0_4000;

  // ==========================================
  // pin encodings
  localparam logic format_spi = 1'b0;
  localparam logic format_frame_sync = 1'b1;

  typedef enum logic [1:0] {
    filter_wideband_one,
    filter_wideband_two,
    filter_low_latency,
    filter_reserved
  } filter_type;

  typedef struct packed {
    logic high_resolution_pin_state;
    logic [1:0] oversampling_ratio_pin_state;
    filter_type filter_pin_state;
    logic interface_format_pin_state;
    logic frame_role_pin_state;
  } pin_settings_type;

  typedef struct packed {
    logic write;
    logic read;
    logic [2:0] addr;
    logic [7:0] wdata;
  } reg_request_type;

  typedef struct packed {
    logic gain_correction_enable;
    logic offset_correction_enable;
    logic [16:0] idle_timeout_cycles;
    logic serial_idle_timeout_enable;
    logic status_byte_disable;
    logic status_crc_width_select;
    logic [23:0] offset_correction_value;
    logic [15:0] gain_correction_value;
  } adc_controls_type;

endpackage

// ---- rtl/adc_config_register_bank.sv ----
// register bank of the delta-sigma adc: identity, configuration, correction values, pin mirror
// assumes one-cycle read or write strobes from the serial command decoder, synchronous to clk
`timescale 1ns/100ps
module adc_config_register_bank #(
  // arbitrary value, not a real part code
  parameter logic [4:0] silicon_revision_field = 5'h01,
  // arbitrary value, not a real part code
  parameter logic [2:0] family_code_field = 3'h5
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port from the command decoder
  input wire adc_regs_pkg::reg_request_type request,
  output logic [7:0] rdata,
  output logic rvalid,
  // hardware mode pins
  input wire adc_regs_pkg::pin_settings_type pins,
  // controls to the conversion path and serial interface
  output adc_regs_pkg::adc_controls_type controls
);

  // ==========================================
  // storage and decode nets
  wire logic [7:0] configuration;
  wire logic [7:0] offset_low;
  wire logic [7:0] offset_mid;
  wire logic [7:0] offset_high;
  wire logic [7:0] gain_low;
  wire logic [7:0] gain_high;
  wire logic [7:0] next_rdata;
  wire logic spi_mode;
  wire logic write_ok;
  wire logic read_ok;
  wire logic [7:0] identity_word;
  wire logic [7:0] pin_word;
  // one-hot address decode
  wire logic hit_identity;
  wire logic hit_configuration;
  wire logic hit_offset_low;
  wire logic hit_offset_mid;
  wire logic hit_offset_high;
  wire logic hit_gain_low;
  wire logic hit_gain_high;
  wire logic hit_pin_settings;
  // per-register write strobes
  wire logic write_configuration;
  wire logic write_offset_low;
  wire logic write_offset_mid;
  wire logic write_offset_high;
  wire logic write_gain_low;
  wire logic write_gain_high;
  // read selection terms
  wire logic [7:0] read_identity;
  wire logic [7:0] read_configuration;
  wire logic [7:0] read_offset_low;
  wire logic [7:0] read_offset_mid;
  wire logic [7:0] read_offset_high;
  wire logic [7:0] read_gain_low;
  wire logic [7:0] read_gain_high;
  wire logic [7:0] read_pin_settings;
  // control output terms
  wire logic next_gain_correction_enable;
  wire logic next_offset_correction_enable;
  wire logic next_serial_idle_timeout_enable;
  wire logic next_status_byte_disable;
  wire logic next_status_crc_width_select;
  wire logic [16:0] next_idle_timeout_cycles;
  wire logic [23:0] next_offset_correction_value;
  wire logic [15:0] next_gain_correction_value;
  wire adc_regs_pkg::adc_controls_type next_controls;

  // ==========================================
  // access gating
  // frame-sync modes close the register port entirely
  assign spi_mode = (pins.interface_format_pin_state == adc_regs_pkg::format_spi);
  assign write_ok = request.write & spi_mode;
  assign read_ok = request.read & spi_mode;

  // ==========================================
  // address decode
  assign hit_identity = (request.addr == adc_regs_pkg::addr_identity);
  assign hit_configuration = (request.addr == adc_regs_pkg::addr_configuration);
  assign hit_offset_low = (request.addr == adc_regs_pkg::addr_offset_low);
  assign hit_offset_mid = (request.addr == adc_regs_pkg::addr_offset_mid);
  assign hit_offset_high = (request.addr == adc_regs_pkg::addr_offset_high);
  assign hit_gain_low = (request.addr == adc_regs_pkg::addr_gain_low);
  assign hit_gain_high = (request.addr == adc_regs_pkg::addr_gain_high);
  assign hit_pin_settings = (request.addr == adc_regs_pkg::addr_pin_settings);

  // read-only addresses get no strobe, so a write there has no effect
  assign write_configuration = write_ok & hit_configuration;
  assign write_offset_low = write_ok & hit_offset_low;
  assign write_offset_mid = write_ok & hit_offset_mid;
  assign write_offset_high = write_ok & hit_offset_high;
  assign write_gain_low = write_ok & hit_gain_low;
  assign write_gain_high = write_ok & hit_gain_high;

  // ==========================================
  // read-only words
  assign identity_word = {silicon_revision_field, family_code_field};
  // filter code passes through as-is, reserved code included
  assign pin_word = {
    1'b0,
    pins.high_resolution_pin_state,
    pins.oversampling_ratio_pin_state,
    pins.filter_pin_state,
    pins.interface_format_pin_state,
    pins.frame_role_pin_state
  };

  // ==========================================
  // configuration register
  // top bits held at zero by the mask, so a stray write cannot set them
  adc_byte_register #(
    .reset_value(adc_regs_pkg::configuration_reset),
    .writable_mask(adc_regs_pkg::configuration_writable_mask)
  ) configuration_reg (
    // clock and reset
    .clk(clk),
    .rst(rst),
    // write port
    .write_strobe(write_configuration),
    .write_value(request.wdata),
    // stored byte
    .value(configuration)
  );

  // ==========================================
  // offset correction bytes, written independently
  adc_byte_register #(
    .reset_value(adc_regs_pkg::offset_byte_reset),
    .writable_mask(8'hff)
  ) offset_low_reg (
    // clock and reset
    .clk(clk),
    .rst(rst),
    // write port
    .write_strobe(write_offset_low),
    .write_value(request.wdata),
    // stored byte
    .value(offset_low)
  );

  adc_byte_register #(
    .reset_value(adc_regs_pkg::offset_byte_reset),
    .writable_mask(8'hff)
  ) offset_mid_reg (
    // clock and reset
    .clk(clk),
    .rst(rst),
    // write port
    .write_strobe(write_offset_mid),
    .write_value(request.wdata),
    // stored byte
    .value(offset_mid)
  );

  adc_byte_register #(
    .reset_value(adc_regs_pkg::offset_byte_reset),
    .writable_mask(8'hff)
  ) offset_high_reg (
    // clock and reset
    .clk(clk),
    .rst(rst),
    // write port
    .write_strobe(write_offset_high),
    .write_value(request.wdata),
    // stored byte
    .value(offset_high)
  );

  // ==========================================
  // gain correction bytes, no latching between halves
  adc_byte_register #(
    .reset_value(adc_regs_pkg::gain_low_reset),
    .writable_mask(8'hff)
  ) gain_low_reg (
    // clock and reset
    .clk(clk),
    .rst(rst),
    // write port
    .write_strobe(write_gain_low),
    .write_value(request.wdata),
    // stored byte
    .value(gain_low)
  );

  adc_byte_register #(
    .reset_value(adc_regs_pkg::gain_high_reset),
    .writable_mask(8'hff)
  ) gain_high_reg (
    // clock and reset
    .clk(clk),
    .rst(rst),
    // write port
    .write_strobe(write_gain_high),
    .write_value(request.wdata),
    // stored byte
    .value(gain_high)
  );

  // ==========================================
  // read selection
  assign read_identity = {8{hit_identity}} & identity_word;
  assign read_configuration = {8{hit_configuration}} & configuration;
  assign read_offset_low = {8{hit_offset_low}} & offset_low;
  assign read_offset_mid = {8{hit_offset_mid}} & offset_mid;
  assign read_offset_high = {8{hit_offset_high}} & offset_high;
  assign read_gain_low = {8{hit_gain_low}} & gain_low;
  assign read_gain_high = {8{hit_gain_high}} & gain_high;
  assign read_pin_settings = {8{hit_pin_settings}} & pin_word;
  // a read in the same cycle as a write returns the old value
  assign next_rdata = read_identity | read_configuration | read_offset_low | read_offset_mid
    | read_offset_high | read_gain_low | read_gain_high | read_pin_settings;

  // ==========================================
  // read answer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
    end else begin
      rvalid <= read_ok;
    end
  end

  // data holds until the next accepted read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (read_ok) begin
      rdata <= next_rdata;
    end
  end

  // ==========================================
  // control terms
  assign next_gain_correction_enable = configuration[adc_regs_pkg::gain_correction_enable_bit];
  assign next_offset_correction_enable = configuration[adc_regs_pkg::offset_correction_enable_bit];
  assign next_idle_timeout_cycles = configuration[adc_regs_pkg::idle_timeout_length_select_bit]
    ? adc_regs_pkg::idle_timeout_short_cycles : adc_regs_pkg::idle_timeout_long_cycles;
  assign next_serial_idle_timeout_enable = configuration[adc_regs_pkg::serial_idle_timeout_enable_bit];
  assign next_status_byte_disable = configuration[adc_regs_pkg::status_byte_disable_bit];
  assign next_status_crc_width_select = configuration[adc_regs_pkg::status_crc_width_select_bit];
  assign next_offset_correction_value = {offset_high, offset_mid, offset_low};
  assign next_gain_correction_value = {gain_high, gain_low};

  assign next_controls = '{
    gain_correction_enable: next_gain_correction_enable,
    offset_correction_enable: next_offset_correction_enable,
    idle_timeout_cycles: next_idle_timeout_cycles,
    serial_idle_timeout_enable: next_serial_idle_timeout_enable,
    status_byte_disable: next_status_byte_disable,
    status_crc_width_select: next_status_crc_width_select,
    offset_correction_value: next_offset_correction_value,
    gain_correction_value: next_gain_correction_value
  };

  // ==========================================
  // registered control outputs
  // one extra stage so every output leaves a flip-flop; controls lag a write by two edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      controls <= '0;
      controls.gain_correction_value <= {adc_regs_pkg::gain_high_reset, adc_regs_pkg::gain_low_reset};
      controls.idle_timeout_cycles <= adc_regs_pkg::idle_timeout_long_cycles;
    end else begin
      controls <= next_controls;
    end
  end

endmodule

// ==========================================
// one stored byte with a write mask
`timescale 1ns/100ps
module adc_byte_register #(
  parameter logic [7:0] reset_value = 8'h00,
  parameter logic [7:0] writable_mask = 8'hff
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // write port
  input wire logic write_strobe,
  input wire logic [7:0] write_value,
  // stored byte
  output logic [7:0] value
);

  wire logic [7:0] masked_value;

  // masked bits never store a one, whatever the host sends
  assign masked_value = write_value & writable_mask;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value <= reset_value;
    end else if (write_strobe) begin
      value <= masked_value;
    end
  end

endmodule

// ---- verif/adc_host.sv ----
// host model driving the register bank command port
// assumes the bench sets the mode pins
`timescale 1ns/100ps
module adc_host (
  // command port
  input wire logic clk,
  output adc_regs_pkg::reg_request_type request,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  // ==========
  // bus cycles
  initial request = '0;
  // released lines show inverted data so stale values never pass
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    request <= '{1'b1, 1'b0, a, d & ((a == 3'h1) ? 8'h3f : 8'hff)};
    @(posedge clk);
    request <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk);
    request <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    request <= '{1'b0, 1'b0, ~a, 8'hff};
    #1;
    ok = rvalid;
    d = rdata;
  endtask
endmodule

// ---- verif/adc_config_register_bank_props.sv ----
// port checker for the register bank
// assumes bind to the bank below
`timescale 1ns/100ps
module adc_config_register_bank_props #(
  parameter logic [4:0] silicon_revision_field = 5'h01,
  parameter logic [2:0] family_code_field = 3'h5
) (
  input wire logic clk,
  input wire logic rst,
  input wire adc_regs_pkg::reg_request_type request,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire adc_regs_pkg::pin_settings_type pins,
  input wire adc_regs_pkg::adc_controls_type controls
);
  // ==========
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic rd = request.read && !pins.interface_format_pin_state;
  wire logic wr = request.write && !pins.interface_format_pin_state;
  wire logic [4:0] cfg = {controls.gain_correction_enable, controls.offset_correction_enable,
    controls.serial_idle_timeout_enable, controls.status_byte_disable, controls.status_crc_width_select};
  rd_answer_a: assert property (rd |=> rvalid) else $error("read not answered");
  frame_read_a: assert property (request.read && pins.interface_format_pin_state |=> !rvalid)
    else $error("read answered in frame-sync");
  frame_write_a: assert property (request.write && pins.interface_format_pin_state |-> ##2 $stable(controls))
    else $error("write taken in frame-sync");
  ident_read_a: assert property (rd && request.addr == 3'h0 |=> rdata == {silicon_revision_field, family_code_field})
    else $error("identity wrong");
  cfg_fields_a: assert property (wr && request.addr == 3'h1 |-> ##2 cfg ==
    {$past(request.wdata[5:4], 2), $past(request.wdata[2:0], 2)}) else $error("config fields wrong");
  timeout_len_a: assert property (wr && request.addr == 3'h1 |-> ##2 controls.idle_timeout_cycles ==
    ($past(request.wdata[3], 2) ? 17'h0_4000 : 17'h1_0000)) else $error("timeout length wrong");
  cfg_reserved_a: assert property (rd && request.addr == 3'h1 |=> rdata[7:6] == 2'b00) else $error("reserved set");
  offset_high_a: assert property (wr && request.addr == 3'h4 |-> ##2
    controls.offset_correction_value[23:16] == $past(request.wdata, 2)) else $error("offset high wrong");
  gain_low_a: assert property (wr && request.addr == 3'h5 |-> ##2
    controls.gain_correction_value[7:0] == $past(request.wdata, 2)) else $error("gain low wrong");
  pin_mirror_a: assert property (rd && request.addr == 3'h7 |=> rdata == {1'b0, $past(pins)})
    else $error("pin mirror wrong");
  cover property (wr && request.addr == 3'h1);
  cover property (request.read && pins.interface_format_pin_state);
  cover property (rd && request.addr == 3'h7);
endmodule
bind adc_config_register_bank adc_config_register_bank_props #(.silicon_revision_field(silicon_revision_field),
  .family_code_field(family_code_field)) props (.clk(clk), .rst(rst), .request(request), .rdata(rdata),
  .rvalid(rvalid), .pins(pins), .controls(controls));

// ---- verif/adc_config_register_bank_test.sv ----
// self-checking bench for the register bank
// assumes the host model and the bound checker
`timescale 1ns/100ps
module adc_config_register_bank_test;
  // arbitrary identity values
  localparam logic [4:0] rev = 5'h0a;
  localparam logic [2:0] fam = 3'h6;
  logic clk, rst, rvalid, ok;
  logic [7:0] rdata, d;
  adc_regs_pkg::reg_request_type request;
  adc_regs_pkg::pin_settings_type pins;
  adc_regs_pkg::adc_controls_type controls;
  int n_fail, cmp_count;
  wire logic [7:0] cfg = {2'b00, controls.gain_correction_enable, controls.offset_correction_enable,
    controls.idle_timeout_cycles == 17'h0_4000, controls.serial_idle_timeout_enable,
    controls.status_byte_disable, controls.status_crc_width_select};
  adc_config_register_bank #(.silicon_revision_field(rev), .family_code_field(fam)) uut (.clk(clk), .rst(rst),
    .request(request), .rdata(rdata), .rvalid(rvalid), .pins(pins), .controls(controls));
  adc_host host (.clk(clk), .request(request), .rdata(rdata), .rvalid(rvalid));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==========
  // helpers
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    host.rd(a, d, ok);
    chk("rvalid", 1, ok);
    chk("rdata", exp, d);
  endtask
  // controls lag a write by two edges
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // ==========
  // scenarios
  task automatic t_reset;
    rchk(3'h0, {rev, fam});
    for (int a = 1; a < 7; a++) rchk(3'(a), (a == 6) ? 8'h80 : 8'h00);
    chk("gain", 16'h8000, controls.gain_correction_value);
    chk("timeout", 17'h1_0000, controls.idle_timeout_cycles);
  endtask
  task automatic t_config;
    for (int i = 0; i < 6; i++) begin
      host.wr(3'h1, 8'h01 << i);
      settle();
      chk("controls", 8'h01 << i, cfg);
      rchk(3'h1, 8'h01 << i);
    end
  endtask
  task automatic t_values;
    host.wr(3'h2, 8'ha5);
    host.wr(3'h3, 8'h5a);
    host.wr(3'h4, 8'hc3);
    host.wr(3'h5, 8'h12);
    host.wr(3'h6, 8'h34);
    settle();
    chk("offset", 24'hc3_5aa5, controls.offset_correction_value);
    chk("gain", 16'h3412, controls.gain_correction_value);
  endtask
  task automatic t_ro_mode;
    host.wr(3'h0, 8'hff);
    host.wr(3'h7, 8'hff);
    rchk(3'h0, {rev, fam});
    for (int f = 0; f < 4; f++) begin
      @(posedge clk);
      pins <= {f[0], 2'(3 - f), 2'(f), 1'b0, f[1]};
      rchk(3'h7, {1'b0, f[0], 2'(3 - f), 2'(f), 1'b0, f[1]});
    end
  endtask
  task automatic t_frame;
    for (int r = 0; r < 2; r++) begin
      @(posedge clk);
      pins <= {5'h00, 1'b1, r[0]};
      host.wr(3'h5, 8'hee);
      host.rd(3'h5, d, ok);
      chk("refused rvalid", 1'b0, ok);
      settle();
      chk("gain", 16'h3412, controls.gain_correction_value);
    end
    @(posedge clk);
    pins <= '0;
    rchk(3'h5, 8'h12);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    pins = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_config();
    t_values();
    t_ro_mode();
    t_frame();
    finish_test();
  end
endmodule
